// ==== common/utd_defines.svh ====
// Constants for the transmit queue host controller: device register offsets,
// descriptor layout, field positions and the controller's own register map.
// Assumes it is included by bare name from the package and the host controller module.
`ifndef UTD_DEFINES_SVH
`define UTD_DEFINES_SVH

// ==========================================================================
// Device register offsets, relative to the device register base.
`define UTD_DEV_STATE_W0     32'h0000_0000
`define UTD_DEV_COMP_PTR     32'h0000_0018
`define UTD_DEV_PORT_CTRL    32'h0000_001C
`define UTD_DEV_EP_CTRL      32'h0000_0020
`define UTD_DEV_CORE_CTRL    32'h0000_0024
`define UTD_DEV_SEG_EN       32'h0000_0028
`define UTD_STATE_WORDS      3'h6
`define UTD_PORT_EN_BIT      0
`define UTD_EP_DMA_EN_BIT    0
`define UTD_CORE_SEG_BIT     0

// ==========================================================================
// Descriptor layout: four words, byte offsets and flag positions of word 3.
`define UTD_DESC_NEXT_OFS    32'h0000_0000
`define UTD_DESC_FLAGS_OFS   32'h0000_000C
`define UTD_DESC_WORDS       3'h4
`define UTD_DESC_SOP_BIT     31
`define UTD_DESC_EOP_BIT     30
`define UTD_DESC_OWN_BIT     29
`define UTD_DESC_EOQ_BIT     28
`define UTD_DESC_ZERO_BIT    23
`define UTD_ALIGN64_MASK     16'h003F

// ==========================================================================
// Controller register map seen by local software.
`define UTD_REG_CMD          5'h00
`define UTD_REG_CFG          5'h04
`define UTD_REG_DESC         5'h08
`define UTD_REG_BUF          5'h0C
`define UTD_REG_LEN          5'h10
`define UTD_REG_STATUS       5'h14
`define UTD_REG_COUNT        5'h18
`define UTD_REG_LAST         5'h1C
`define UTD_CMD_INIT_BIT     0
`define UTD_CMD_ENABLE_BIT   1
`define UTD_CMD_APPEND_BIT   2
`define UTD_CFG_GLOBAL_BIT   0
`define UTD_CFG_CHAN_BIT     1
`define UTD_MAXPKT_RESET     16'h0040

`endif

// ==== common/utd_pkg.sv ====
// Types shared by the transmit queue host controller modules.
// Assumes the defines header sits in the include path.
`include "utd_defines.svh"

package utd_pkg;

   // ========================================================================
   // Sequencer states of the host controller.
   typedef enum logic [3:0] {
      UTD_IDLE    = 4'b0000,
      UTD_INIT    = 4'b0001,
      UTD_EN_EP   = 4'b0010,
      UTD_EN_PORT = 4'b0011,
      UTD_EN_CORE = 4'b0100,
      UTD_EN_SEG  = 4'b0101,
      UTD_AP_DESC = 4'b0110,
      UTD_AP_LINK = 4'b0111,
      UTD_AP_HEAD = 4'b1000,
      UTD_SC_FLAG = 4'b1001,
      UTD_SC_NEXT = 4'b1010,
      UTD_SC_RSTR = 4'b1011,
      UTD_SC_ACK  = 4'b1100
   } utd_state_e;

endpackage

// ==== core/utd_bus_master.sv ====
// Single-transfer master on the device bus: one write or one read per request.
// Assumes the device answers a read in the cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none

module utd_bus_master
   import utd_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_req,
   input  wire logic        i_req_we,
   input  wire logic [31:0] i_req_addr,
   input  wire logic [31:0] i_req_wdata,
   output logic             o_done,
   output logic [31:0]      o_rdata,
   output logic [31:0]      o_dev_addr,
   output logic [31:0]      o_dev_wdata,
   output logic             o_dev_wr,
   output logic             o_dev_rd,
   input  wire logic [31:0] i_dev_rdata
);

   // ========================================================================
   // State record of the master.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        phase;
      logic        done;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
   } utd_mst_s;

   utd_mst_s s_q;
   utd_mst_s s_d;

   // Strobe for one cycle, wait for the answer cycle, then report done.
   always_comb begin
      s_d       = s_q;
      s_d.wr    = 1'b0;
      s_d.rd    = 1'b0;
      s_d.done  = 1'b0;
      s_d.phase = s_q.wr | s_q.rd;
      if (s_q.phase) begin
         s_d.done  = 1'b1;
         s_d.rdata = i_dev_rdata;  // Read data stand only in this cycle.
      end
      if (i_req && !s_q.wr && !s_q.rd && !s_q.phase) begin
         s_d.wr    = i_req_we;
         s_d.rd    = ~i_req_we;
         s_d.addr  = i_req_addr;
         s_d.wdata = i_req_wdata;
      end
   end

   // Registers the state record.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_done      = s_q.done;
   assign o_rdata     = s_q.rdata;
   assign o_dev_addr  = s_q.addr;
   assign o_dev_wdata = s_q.wdata;
   assign o_dev_wr    = s_q.wr;
   assign o_dev_rd    = s_q.rd;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_strobe_exclusive: assert property (!(o_dev_wr && o_dev_rd))
      else $error("Write and read strobes high together.");
   a_done_after_strobe: assert property ((o_dev_wr || o_dev_rd) |-> ##2 o_done)
      else $error("Done did not follow a strobe by two cycles.");

endmodule

`default_nettype wire

// ==== core/utd_tx_host.sv ====
// Host controller for one transmit channel of a descriptor queue engine.
// Builds descriptors, starts the channel, reclaims packets and acknowledges.
// Assumes device registers and descriptor memory share one device bus.
`timescale 1ns/10ps
`default_nettype none
`include "utd_defines.svh"

// What this block does
// - Clear every transmit state word after reset before starting the channel.
// - Set endpoint transfer enable, then port enable, then write the head pointer.
// - Descriptors hold aligned next pointer, buffer, length, offset; end-of-queue clear.
// - Every packet's first descriptor carries start and ownership flags.
// - Append packets at the tail; the device releases them from the head.
// - On interrupt scan from head, reclaim unowned packets, stop at owned or end.
// - Acknowledge by writing the last processed descriptor into the completion pointer.
// - Unowned final packet with end-of-queue and nonzero next: rewrite head pointer.
// - In transparent mode a packet never exceeds the maximum packet size.
// - Segmentation mode only when the maximum packet size is a multiple of 64.
// - Segmentation enabled globally in core control or per channel enable bit.
module utd_tx_host
   import utd_pkg::*;
#(
   parameter logic [31:0] DEV_BASE = 32'h0000_0000,
   parameter int          CHANNEL  = 0
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic [4:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic [31:0]      o_reg_rdata,
   output logic [31:0]      o_dev_addr,
   output logic [31:0]      o_dev_wdata,
   output logic             o_dev_wr,
   output logic             o_dev_rd,
   input  wire logic [31:0] i_dev_rdata,
   input  wire logic        i_dev_irq
);

   // ========================================================================
   // State record of the controller.
   typedef struct packed {
      utd_state_e  st;
      logic        wait_ack;
      logic [2:0]  idx;
      logic [2:0]  pend;
      logic [31:0] head;
      logic [31:0] tail;
      logic [31:0] last_comp;
      logic [31:0] desc;
      logic [31:0] buf_addr;
      logic [15:0] len;
      logic [15:0] maxpkt;
      logic [15:0] count;
      logic        end_of_queue_flag;
      logic        active;
      logic        seg_global;
      logic        seg_chan;
      logic        error;
      logic [31:0] rdata;
   } utd_host_s;

   utd_host_s   s_q;
   utd_host_s   s_d;
   logic        req;
   logic        req_we;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic        mst_done;
   logic [31:0] mst_rdata;
   logic        seg_ok;
   logic        seg_on;

   // Segmentation is only legal with a maximum packet size aligned to 64.
   assign seg_ok = (s_q.maxpkt & `UTD_ALIGN64_MASK) == 16'h0000;
   assign seg_on = (s_q.seg_global | s_q.seg_chan) & seg_ok;

   // ========================================================================
   // Bus request for the current step; one transfer per state, one per word in UTD_INIT and UTD_AP_DESC.
   always_comb begin
      req       = (s_q.st != UTD_IDLE) && !s_q.wait_ack;
      req_we    = 1'b1;
      req_addr  = DEV_BASE;
      req_wdata = 32'h0000_0000;
      unique case (s_q.st)
         UTD_IDLE: begin
            req = 1'b0;
         end
         UTD_INIT: begin
            req_addr = DEV_BASE + `UTD_DEV_STATE_W0 + 32'({s_q.idx, 2'b00});
         end
         UTD_EN_EP: begin
            req_addr  = DEV_BASE + `UTD_DEV_EP_CTRL;
            req_wdata = 32'h0000_0001 << `UTD_EP_DMA_EN_BIT;
         end
         UTD_EN_PORT: begin
            req_addr  = DEV_BASE + `UTD_DEV_PORT_CTRL;
            req_wdata = 32'h0000_0001 << `UTD_PORT_EN_BIT;
         end
         UTD_EN_CORE: begin
            req_addr  = DEV_BASE + `UTD_DEV_CORE_CTRL;
            req_wdata = 32'({s_q.seg_global & seg_ok}) << `UTD_CORE_SEG_BIT;
         end
         UTD_EN_SEG: begin
            req_addr  = DEV_BASE + `UTD_DEV_SEG_EN;
            req_wdata = 32'({s_q.seg_chan & seg_ok}) << CHANNEL;
         end
         UTD_AP_DESC: begin
            req_addr = s_q.desc + 32'({s_q.idx, 2'b00});
            // Word 0 next pointer stays zero: the new packet is the last one.
            if (s_q.idx == 3'h1) begin
               req_wdata = s_q.buf_addr;
            end else if (s_q.idx == 3'h2) begin
               req_wdata = {16'h0000, s_q.len};
            end else if (s_q.idx == 3'h3) begin
               req_wdata = {16'h0000, s_q.len};
               req_wdata[`UTD_DESC_SOP_BIT]  = 1'b1;
               req_wdata[`UTD_DESC_EOP_BIT]  = 1'b1;
               req_wdata[`UTD_DESC_OWN_BIT]  = 1'b1;
               req_wdata[`UTD_DESC_ZERO_BIT] = (s_q.len == 16'h0000);
            end
         end
         UTD_AP_LINK: begin
            req_addr  = s_q.tail + `UTD_DESC_NEXT_OFS;
            req_wdata = s_q.desc;
         end
         UTD_AP_HEAD: begin
            req_addr  = DEV_BASE + `UTD_DEV_STATE_W0;
            req_wdata = s_q.desc;
         end
         UTD_SC_FLAG: begin
            req_we   = 1'b0;
            req_addr = s_q.head + `UTD_DESC_FLAGS_OFS;
         end
         UTD_SC_NEXT: begin
            req_we   = 1'b0;
            req_addr = s_q.head + `UTD_DESC_NEXT_OFS;
         end
         UTD_SC_RSTR: begin
            req_addr  = DEV_BASE + `UTD_DEV_STATE_W0;
            req_wdata = s_q.head;
         end
         UTD_SC_ACK: begin
            req_addr  = DEV_BASE + `UTD_DEV_COMP_PTR;
            req_wdata = s_q.last_comp;
         end
         default: begin
            req = 1'b0;
         end
      endcase
   end

   // ========================================================================
   // Register port, command latching and the sequencer.
   always_comb begin
      s_d       = s_q;
      s_d.rdata = 32'h0000_0000;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            `UTD_REG_CFG:    s_d.rdata = {s_q.maxpkt, 14'h0000, s_q.seg_chan, s_q.seg_global};
            `UTD_REG_DESC:   s_d.rdata = s_q.desc;
            `UTD_REG_BUF:    s_d.rdata = s_q.buf_addr;
            `UTD_REG_LEN:    s_d.rdata = {16'h0000, s_q.len};
            `UTD_REG_STATUS: s_d.rdata = {23'h000000, s_q.st, i_dev_irq, seg_on, s_q.active,
                                          s_q.error, s_q.st != UTD_IDLE};
            `UTD_REG_COUNT:  s_d.rdata = {16'h0000, s_q.count};
            `UTD_REG_LAST:   s_d.rdata = s_q.last_comp;
            default:         s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Sequencer step: a request is issued once, then the step waits for done.
      if (req) begin
         s_d.wait_ack = 1'b1;
      end
      if (mst_done) begin
         s_d.wait_ack = 1'b0;
         unique case (s_q.st)
            UTD_INIT: begin
               s_d.idx = s_q.idx + 3'h1;
               if (s_q.idx == `UTD_STATE_WORDS - 3'h1) begin
                  s_d.st     = UTD_IDLE;
                  s_d.idx    = 3'h0;
                  s_d.active = 1'b0;
                  s_d.head   = 32'h0000_0000;
               end
            end
            UTD_EN_EP:   s_d.st = UTD_EN_PORT;
            UTD_EN_PORT: s_d.st = UTD_EN_CORE;
            UTD_EN_CORE: s_d.st = UTD_EN_SEG;
            UTD_EN_SEG:  s_d.st = UTD_IDLE;
            UTD_AP_DESC: begin
               s_d.idx = s_q.idx + 3'h1;
               if (s_q.idx == `UTD_DESC_WORDS - 3'h1) begin
                  s_d.idx = 3'h0;
                  s_d.st  = s_q.active ? UTD_AP_LINK : UTD_AP_HEAD;
               end
            end
            UTD_AP_LINK, UTD_AP_HEAD: begin
               s_d.st     = UTD_IDLE;
               s_d.tail   = s_q.desc;
               s_d.active = 1'b1;
               if (!s_q.active) begin
                  s_d.head = s_q.desc;
               end
            end
            UTD_SC_FLAG: begin
               s_d.end_of_queue_flag = mst_rdata[`UTD_DESC_EOQ_BIT];
               if (mst_rdata[`UTD_DESC_OWN_BIT]) begin
                  s_d.st = UTD_SC_ACK;  // Still owned: the scan stops here.
               end else begin
                  s_d.st        = UTD_SC_NEXT;
                  s_d.last_comp = s_q.head;
                  s_d.count     = s_q.count + 16'h0001;
               end
            end
            UTD_SC_NEXT: begin
               s_d.head = mst_rdata;
               if (mst_rdata == 32'h0000_0000) begin
                  s_d.st     = UTD_SC_ACK;
                  s_d.active = 1'b0;
               end else begin
                  s_d.st = s_q.end_of_queue_flag ? UTD_SC_RSTR : UTD_SC_FLAG;
               end
            end
            UTD_SC_RSTR: s_d.st = UTD_SC_FLAG;
            UTD_SC_ACK:  s_d.st = UTD_IDLE;
            default:     s_d.st = s_q.st;
         endcase
      end
      // Idle dispatch: interrupt scan first, then init, enable, append.
      if (s_q.st == UTD_IDLE) begin
         if (i_dev_irq && s_q.active) begin
            s_d.st = UTD_SC_FLAG;
         end else if (s_q.pend[`UTD_CMD_INIT_BIT]) begin
            s_d.st                    = UTD_INIT;
            s_d.pend[`UTD_CMD_INIT_BIT] = 1'b0;
         end else if (s_q.pend[`UTD_CMD_ENABLE_BIT]) begin
            s_d.st                      = UTD_EN_EP;
            s_d.pend[`UTD_CMD_ENABLE_BIT] = 1'b0;
            s_d.error                   = s_q.error | ((s_q.seg_global | s_q.seg_chan) & ~seg_ok);
         end else if (s_q.pend[`UTD_CMD_APPEND_BIT]) begin
            s_d.pend[`UTD_CMD_APPEND_BIT] = 1'b0;
            if (!seg_on && (s_q.len > s_q.maxpkt)) begin
               s_d.error = 1'b1;
            end else begin
               s_d.st = UTD_AP_DESC;
            end
         end
      end
      // Register writes; a new command bit wins over its own clear.
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            `UTD_REG_CMD: begin
               s_d.pend = s_d.pend | i_reg_wdata[2:0];
               if (i_reg_wdata[`UTD_CMD_INIT_BIT]) begin
                  s_d.error = s_d.error & ~s_q.error;  // Init clears a stored error; one raised this cycle stays only when none was stored.
               end
            end
            `UTD_REG_CFG: begin
               s_d.seg_global = i_reg_wdata[`UTD_CFG_GLOBAL_BIT];
               s_d.seg_chan   = i_reg_wdata[`UTD_CFG_CHAN_BIT];
               s_d.maxpkt     = i_reg_wdata[31:16];
            end
            `UTD_REG_DESC: s_d.desc = i_reg_wdata;
            `UTD_REG_BUF:  s_d.buf_addr = i_reg_wdata;
            `UTD_REG_LEN:  s_d.len = i_reg_wdata[15:0];
            default: s_d.pend = s_d.pend;
         endcase
      end
   end

   // Registers the state record.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q        <= '0;
         s_q.maxpkt <= `UTD_MAXPKT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_reg_rdata = s_q.rdata;

   // Device bus transfer engine.
   utd_bus_master utd_bus_master_inst (
      .i_clock     (i_clock),
      .i_rst_n     (i_rst_n),
      .i_req       (req),
      .i_req_we    (req_we),
      .i_req_addr  (req_addr),
      .i_req_wdata (req_wdata),
      .o_done      (mst_done),
      .o_rdata     (mst_rdata),
      .o_dev_addr  (o_dev_addr),
      .o_dev_wdata (o_dev_wdata),
      .o_dev_wr    (o_dev_wr),
      .o_dev_rd    (o_dev_rd),
      .i_dev_rdata (i_dev_rdata)
   );

   // ========================================================================
   // Checks on the requests the sequencer makes.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_init_zero_words: assert property ((req && s_q.st == UTD_INIT) |-> ##1 (o_dev_wr && o_dev_wdata == 32'h0))
      else $error("State word cleared with a nonzero value.");
   a_enable_sequence: assert property ((mst_done && s_q.st == UTD_EN_EP) |=> (s_q.st == UTD_EN_PORT && req))
      else $error("Port enable did not follow endpoint enable.");
   a_head_nonzero: assert property ((req && s_q.st == UTD_AP_HEAD) |-> ##1 o_dev_wdata != 32'h0)
      else $error("Head pointer written with a zero address.");
   a_desc_flag_word: assert property ((req && s_q.st == UTD_AP_DESC && s_q.idx == 3'h3)
      |-> (req_wdata[31:28] == 4'b1110 && req_wdata[15:0] == s_q.len))
      else $error("First descriptor flags wrong.");
   a_desc_next_zero: assert property ((req && s_q.st == UTD_AP_DESC && s_q.idx == 3'h0) |-> req_wdata == 32'h0)
      else $error("New tail descriptor has a nonzero next pointer.");
   a_len_in_limit: assert property ($rose(s_q.st == UTD_AP_DESC) && !seg_on |-> s_q.len <= s_q.maxpkt)
      else $error("Transparent packet longer than maximum packet size.");
   a_seg_aligned: assert property ((req && s_q.st == UTD_EN_CORE && req_wdata != 32'h0) |-> seg_ok)
      else $error("Segmentation enabled with unaligned packet size.");
   a_ack_value: assert property ((req && s_q.st == UTD_SC_ACK) |-> ##1 (o_dev_wdata == s_q.last_comp))
      else $error("Acknowledge value differs from last reclaimed descriptor.");
   a_restart_nonzero: assert property ((req && s_q.st == UTD_SC_RSTR) |-> req_wdata != 32'h0)
      else $error("Restart written with a zero head pointer.");

   c_append: cover property (mst_done && s_q.st == UTD_AP_LINK);
   c_restart: cover property (mst_done && s_q.st == UTD_SC_RSTR);
   c_ack: cover property (mst_done && s_q.st == UTD_SC_ACK);
   c_init: cover property (mst_done && s_q.st == UTD_INIT && s_q.idx == 3'h5);

endmodule

`default_nettype wire

// ==== dv/utd_dev_model.sv ====
// Behavioural model of the transmit queue device: state words, descriptor memory, irq.
// Assumes it sits at device base zero with descriptors below address 0x400.
`timescale 1ns/10ps
`default_nettype none

module utd_dev_model #(
   parameter int DELAY  = 60,
   parameter int MAXPKT = 64
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   output logic             o_irq
);
   // ========================================================================
   // Registers and memory share one word array; the pattern keeps bit 0 low.
   logic [31:0] mem [0:255];
   logic [31:0] cur, comp, nx;
   int          cnt, k, len, usb_pkts;
   initial for (int i = 0; i < 256; i++) mem[i] = 32'hA5A5_0000 | (i << 4);
   // Answers reads one cycle late, toggles otherwise, and walks the queue.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0;
         o_irq   <= 1'b0;
         cur = 32'h0;
         comp = 32'h0;
         cnt = 0;
         usb_pkts = 0;
      end else begin
         o_rdata <= i_rd ? mem[i_addr[9:2]] : ~o_rdata;
         if (i_wr) begin
            mem[i_addr[9:2]] = i_wdata;
            if (i_addr == 32'h0 && i_wdata != 32'h0) begin
               cur = i_wdata;
               cnt = DELAY;
            end
            if (i_addr == 32'h18 && i_wdata == comp) o_irq <= 1'b0;
         end
         if (cur != 32'h0 && mem[7][0] && mem[8][0]) begin
            if (cnt > 0) cnt--;
            else begin
               k = int'(cur[9:2]);
               nx = mem[k];
               mem[1] = cur;
               mem[2] = cur;
               mem[k+3][29] = 1'b0;
               // Counts the bus packets that this packet turns into on the endpoint.
               len = int'(mem[k+3][15:0]);
               if (int'(mem[k+2][15:0]) < len) len = int'(mem[k+2][15:0]);
               if (mem[k+3][23]) len = 0;
               if (mem[9][0] || mem[10][0]) usb_pkts += len / MAXPKT + 1;
               else usb_pkts += 1;
               if (nx == 32'h0) mem[k+3][28] = 1'b1;
               comp = cur;
               mem[6] = cur;
               o_irq <= 1'b1;
               cur = nx;
               cnt = DELAY;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/utd_tx_host_tb_top.sv ====
// Testbench for the transmit queue host controller against the device model.
// Assumes the design, package and model compile first.
`timescale 1ns/10ps
`default_nettype none

module utd_tx_host_tb_top;
   import utd_pkg::*;
   logic        i_clock = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, o_dev_wr, o_dev_rd, dev_irq;
   logic [4:0]  i_reg_addr = 0;
   logic [31:0] i_reg_wdata = 0, o_reg_rdata, o_dev_addr, o_dev_wdata, dev_rdata, d;
   int          failures = 0, comparisons = 0, cycles = 0;
   // ========================================================================
   // Clock, timeout and instances.
   always #2 i_clock = ~i_clock;
   always @(posedge i_clock) if (++cycles == 40000) begin failures++; finish_test(); end
   utd_tx_host utd_tx_host_inst (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .o_dev_addr, .o_dev_wdata, .o_dev_wr, .o_dev_rd, .i_dev_rdata(dev_rdata), .i_dev_irq(dev_irq));
   utd_dev_model utd_dev_model_inst (.i_clock, .i_rst_n, .i_addr(o_dev_addr), .i_wdata(o_dev_wdata),
      .i_wr(o_dev_wr), .i_rd(o_dev_rd), .o_rdata(dev_rdata), .o_irq(dev_irq));
   // ========================================================================
   // Shared bus and compare tasks.
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin failures++; $display("Error %s expected %h seen %h", n, e, g); end
   endtask
   task automatic wr(logic [4:0] a, logic [31:0] v);
      @(posedge i_clock); i_reg_addr <= a; i_reg_wdata <= v; i_reg_wr <= 1'b1;
      @(posedge i_clock); i_reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a);
      @(posedge i_clock); i_reg_addr <= a; i_reg_rd <= 1'b1;
      @(posedge i_clock); i_reg_rd <= 1'b0; #1 d = o_reg_rdata;
   endtask
   function automatic logic [31:0] m(int a); return utd_dev_model_inst.mem[a >> 2]; endfunction
   // Waits for the command to start, then for idle with the queue drained.
   task automatic settle();
      int n = 0;
      do begin rd(5'h14); n++; end while (d[0] !== 1'b1 && n < 8);
      do begin rd(5'h14); n++; end while ((d[0] | d[2]) !== 1'b0 && n < 3000);
      if (n >= 3000) begin failures++; $display("Error settle timeout"); end
   endtask
   // ========================================================================
   // Scenarios.
   task automatic t_enable();
      wr(5'h00, 32'h1); settle();
      for (int i = 0; i < 24; i += 4) chk("state word", 32'h0, m(i));
      wr(5'h04, 32'h0041_0001); wr(5'h00, 32'h2); settle(); rd(5'h14);
      chk("error bit", 32'h1, {31'h0, d[1]});
      chk("core seg", 32'h0, m(32'h24));
      wr(5'h00, 32'h1); settle(); wr(5'h04, 32'h0040_0002); wr(5'h00, 32'h2); settle(); rd(5'h14);
      chk("seg status", 32'h1, {31'h0, d[3]});
      chk("chan seg", 32'h1, m(32'h28));
      wr(5'h04, 32'h0040_0000); wr(5'h00, 32'h2); settle();
      chk("chan seg off", 32'h0, m(32'h28));
      chk("ep enable", 32'h1, m(32'h20));
      chk("port enable", 32'h1, m(32'h1C));
   endtask
   task automatic t_send(logic [31:0] a, logic [15:0] len, logic [31:0] cnt);
      wr(5'h08, a); wr(5'h0C, 32'h80); wr(5'h10, {16'h0, len}); wr(5'h00, 32'h4); settle();
      chk("head", a, m(0));
      chk("buffer", 32'h80, m(a + 4));
      chk("length", {16'h0, len}, m(a + 8));
      chk("flags", 32'hD000_0000 | (len == 0 ? 32'h0080_0000 : 32'h0) | len, m(a + 12));
      rd(5'h18); chk("count", cnt, d);
      rd(5'h1C); chk("last", a, d);
      chk("ack", a, m(32'h18));
      chk("irq", 32'h0, {31'h0, dev_irq});
   endtask
   task automatic t_refuse();
      wr(5'h10, 32'h41); wr(5'h00, 32'h4); settle(); rd(5'h14);
      chk("oversize error", 32'h1, {31'h0, d[1]});
      rd(5'h18); chk("count kept", 32'h2, d);
      rd(5'h1B); chk("unmapped", 32'h0, d);
      wr(5'h00, 32'h3);
      settle();
      settle(); // Init and enable run back to back; the second wait covers the enable.
   endtask
   task automatic t_two();
      wr(5'h08, 32'h200); wr(5'h0C, 32'h80); wr(5'h10, 32'h10); wr(5'h00, 32'h4);
      repeat (30) @(posedge i_clock); // Lets the first append finish before its registers change.
      wr(5'h08, 32'h300); wr(5'h10, 32'h20); wr(5'h00, 32'h4); settle();
      chk("tail link", 32'h300, m(32'h200));
      chk("first flags", 32'hC000_0010, m(32'h20C));
      chk("second flags", 32'hD000_0020, m(32'h30C));
      rd(5'h18); chk("count two", 32'h4, d);
      rd(5'h1C); chk("last two", 32'h300, d);
   endtask
   // Segmentation mode: an exact multiple ends with an empty packet, other lengths with a short one.
   task automatic t_seg();
      wr(5'h04, 32'h0040_0001);
      wr(5'h00, 32'h2);
      settle();
      t_send(32'h180, 16'h80, 32'h5);
      chk("usb packets exact", 32'h7, utd_dev_model_inst.usb_pkts);
      t_send(32'h1C0, 16'h50, 32'h6);
      chk("usb packets short", 32'h9, utd_dev_model_inst.usb_pkts);
   endtask
   task automatic finish_test();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ========================================================================
   // Main sequence.
   initial begin
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      t_enable();
      t_send(32'h100, 16'h40, 32'h1);
      t_send(32'h140, 16'h0, 32'h2);
      t_refuse();
      t_two();
      t_seg();
      finish_test();
   end
endmodule
`default_nettype wire
